// ---- design/gloe_consts.vh ----
`ifndef GLOE_CONSTS_VH
`define GLOE_CONSTS_VH

// clock rate of clock_i in MHz (40 ns period)
`define GLOE_CLK_MHZ       25
// supply settling time before the runt suppressor leaves reset, in microseconds
`define GLOE_POR_TIME_US   12000
// settle cycles = time * rate (12000 us at 25 MHz), sized to the counter width
`define GLOE_POR_CYCLES    20'h493e0
// width of the settle counter, enough for the default count
`define GLOE_POR_CNT_W     20
// levels held by the outputs while disabled or in reset, then the gate reset state and the plain bit values
`define GLOE_TRUE_IDLE     1'b0
`define GLOE_COMP_IDLE     1'b1
`define GLOE_GATE_RST      1'b0
`define GLOE_BIT_CLR       1'b0
`define GLOE_BIT_SET       1'b1

`endif

// ---- design/gloe_por_delay.v ----
`timescale 1ns/1ps
`include "gloe_consts.vh"

module gloe_por_delay #(
  parameter                     CNT_W  = `GLOE_POR_CNT_W,
  parameter [CNT_W-1:0]         CYCLES = `GLOE_POR_CYCLES
) (
  input  wire                   clock_i,
  input  wire                   sys_rst_i,
  output wire                   settled_o
);

  reg  [CNT_W-1:0]              cnt_q;
  reg                           done_q;

  ////////////////////////////////////////////////////////////////////////////////
  // counts from reset release; done stays set until the next reset
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_q  <= {CNT_W{1'b0}};
      done_q <= `GLOE_BIT_CLR;
    end else if (!done_q) begin
      if (cnt_q == CYCLES - {{(CNT_W-1){1'b0}}, 1'b1}) begin
        done_q <= `GLOE_BIT_SET;
      end else begin
        cnt_q  <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign settled_o = done_q;

endmodule // gloe_por_delay

// ---- design/gloe_output_gate.v ----
`timescale 1ns/1ps
`include "gloe_consts.vh"

// How it works
// - the enable state changes only at a falling edge of the chosen clock, true output low.
// - after the enable falls, the outputs follow the chosen clock until disable takes effect.
// - on disable, the next falling edge forces the true output low and the complement high.
// - after the enable rises, the outputs follow the chosen clock from its next falling edge.
// - the runt suppressor is held in reset at power-up until a supply settle delay runs out.
// - the clock whose falling edges time enable and disable is the one src_sel_i chooses.

module gloe_output_gate #(
  parameter                     POR_CNT_W  = `GLOE_POR_CNT_W,
  parameter [POR_CNT_W-1:0]     POR_CYCLES = `GLOE_POR_CYCLES
) (
  input  wire                   clock_i,
  input  wire                   sys_rst_i,
  input  wire                   in0_clk_i,
  input  wire                   in1_clk_i,
  input  wire                   src_sel_i,
  input  wire                   out_en_i,
  output wire                   clk_true_o,
  output wire                   clk_comp_o,
  output wire                   runt_suppressor_ready_o
);

  // reset hold and falling-edge decode
  wire                          settled;
  reg                           hold;
  reg                           sel_clk;
  reg                           fall;

  // flops and their next values
  reg                           prev_q;
  reg                           prev_d;
  reg  [0:0]                    gate_q;
  reg  [0:0]                    gate_d;
  reg                           true_q;
  reg                           true_d;
  reg                           comp_q;
  reg                           comp_d;

  ////////////////////////////////////////////////////////////////////////////////
  // gate states, binary coded
  localparam [0:0]              GATE_SHUT = 1'h0;
  localparam [0:0]              GATE_OPEN = 1'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // input choice, shared by the level and the edge decode
  function sel_clk_of;
    input                       sel;
    input                       clk0;
    input                       clk1;

    begin
      if (sel) begin
        sel_clk_of = clk1;
      end else begin
        sel_clk_of = clk0;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // a falling edge is a high sample followed by a low one
  function fall_of;
    input                       prev;
    input                       now;

    begin
      fall_of = prev & ~now;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // only a falling edge of the chosen input may move the gate
  function [0:0] gate_next_of;
    input  [0:0]                state;
    input                       at_fall;
    input                       enable;

    begin
      gate_next_of = state;
      case (state)
        GATE_SHUT: begin
          if (at_fall && enable) begin
            gate_next_of = GATE_OPEN;
          end
        end
        GATE_OPEN: begin
          if (at_fall && !enable) begin
            gate_next_of = GATE_SHUT;
          end
        end
        default: begin
          gate_next_of = GATE_SHUT;
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  gloe_por_delay #(
    .CNT_W     (POR_CNT_W),
    .CYCLES    (POR_CYCLES)
  ) u_por (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .settled_o (settled)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // the suppressor stays idle in reset and until the supply delay has run out
  always @* begin
    if (sys_rst_i) begin
      hold = `GLOE_BIT_SET;
    end else if (!settled) begin
      hold = `GLOE_BIT_SET;
    end else begin
      hold = `GLOE_BIT_CLR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // only the chosen input times the gate; the switchover itself is not glitch-free here
  always @* begin
    sel_clk = sel_clk_of(src_sel_i, in0_clk_i, in1_clk_i);
  end

  always @* begin
    fall = fall_of(prev_q, sel_clk);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next values
  always @* begin
    prev_d = sel_clk;
  end

  always @* begin
    gate_d = gate_next_of(gate_q, fall, out_en_i);
  end

  // the gate stays open between the enable falling and the next falling edge
  always @* begin
    true_d = `GLOE_TRUE_IDLE;
    case (gate_d)
      GATE_SHUT: begin
        true_d = `GLOE_TRUE_IDLE;
      end
      GATE_OPEN: begin
        true_d = sel_clk;
      end
      default: begin
        true_d = `GLOE_TRUE_IDLE;
      end
    endcase
  end

  always @* begin
    comp_d = `GLOE_COMP_IDLE;
    case (gate_d)
      GATE_SHUT: begin
        comp_d = `GLOE_COMP_IDLE;
      end
      GATE_OPEN: begin
        comp_d = ~sel_clk;
      end
      default: begin
        comp_d = `GLOE_COMP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // edge history; cleared so a low first sample is no falling edge
  always @(posedge clock_i) begin
    if (hold) begin
      prev_q <= `GLOE_BIT_CLR;
    end else begin
      prev_q <= prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gate state; a new enable or disable lands here, at a falling edge only
  always @(posedge clock_i) begin
    if (hold) begin
      gate_q <= `GLOE_GATE_RST;
    end else begin
      gate_q <= gate_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // true output; a flop so the pin never sees decode glitches
  always @(posedge clock_i) begin
    if (hold) begin
      true_q <= `GLOE_TRUE_IDLE;
    end else begin
      true_q <= true_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // complement output, the inverse of the true output outside reset
  always @(posedge clock_i) begin
    if (hold) begin
      comp_q <= `GLOE_COMP_IDLE;
    end else begin
      comp_q <= comp_d;
    end
  end

  assign clk_true_o              = true_q;
  assign clk_comp_o              = comp_q;
  assign runt_suppressor_ready_o = settled;

endmodule // gloe_output_gate

// ---- test/gloe_clk_src.sv ----
`timescale 1ns/1ps
module gloe_clk_src (
  input  wire        clock_i,
  output logic       in0_clk_o,
  output logic       in1_clk_o
);
  logic [2:0] k;
  initial begin
    k = 3'h0;
    in0_clk_o = 1'h0;
    in1_clk_o = 1'h0;
  end
  // slow sources: every level spans two or more samples
  always @(posedge clock_i) begin
    k <= k + 3'h1;
    if (k[1:0] == 2'h3) in0_clk_o <= ~in0_clk_o;
    if (k == 3'h2 || k == 3'h5) in1_clk_o <= ~in1_clk_o;
  end
endmodule // gloe_clk_src

// ---- test/gloe_chk_assertions.sv ----
`timescale 1ns/1ps
module gloe_chk (
  input wire clock_i,
  input wire sys_rst_i,
  input wire in0_clk_i,
  input wire in1_clk_i,
  input wire src_sel_i,
  input wire out_en_i,
  input wire clk_true_o,
  input wire clk_comp_o,
  input wire runt_suppressor_ready_o
);
  wire s = src_sel_i ? in1_clk_i : in0_clk_i;
  wire r = runt_suppressor_ready_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // the edge history is live only once ready was already high one sample back
  sequence fall_s;
    r && $past(r) && $past(s) && !s;
  endsequence
  comp_inverse_a:
    assert property (clk_comp_o == !clk_true_o) else $error("complement not inverse");
  settle_idle_a:
    assert property (!r |-> !clk_true_o && clk_comp_o) else $error("active before settle");
  change_low_a:
    assert property ($changed(clk_true_o) |-> clk_true_o == $past(s))
      else $error("output change off clock");
  keep_follow_a:
    assert property (clk_true_o && s |=> clk_true_o) else $error("high pulse cut short");
  off_hold_a:
    assert property (fall_s ##0 !out_en_i |=> !clk_true_o [*2]) else $error("disable late");
  on_follow_a:
    assert property (fall_s ##0 out_en_i |=> ##1 clk_true_o == $past(s)) else $error("enable late");
endmodule // gloe_chk
bind gloe_output_gate gloe_chk u_chk (
  .clock_i                 (clock_i),
  .sys_rst_i               (sys_rst_i),
  .in0_clk_i               (in0_clk_i),
  .in1_clk_i               (in1_clk_i),
  .src_sel_i               (src_sel_i),
  .out_en_i                (out_en_i),
  .clk_true_o              (clk_true_o),
  .clk_comp_o              (clk_comp_o),
  .runt_suppressor_ready_o (runt_suppressor_ready_o)
);

// ---- test/test_glitchless_output_enable.sv ----
`timescale 1ns/1ps
`define CK(n, e, v) begin \
  n_compared++; \
  if ((v) !== (e)) begin \
    n_errors++; \
    $display("BAD %s exp %h got %h", n, e, v); \
  end \
end
module test_glitchless_output_enable;
  logic clock_i   = 1'h0;
  logic sys_rst_i = 1'h1;
  logic src_sel_i = 1'h0;
  logic out_en_i  = 1'h0;
  wire  in0_clk_i;
  wire  in1_clk_i;
  wire  clk_true_o;
  wire  clk_comp_o;
  wire  runt_suppressor_ready_o;
  int   n_errors   = 0;
  int   n_compared = 0;
  gloe_clk_src u_gloe_clk_src (
    .clock_i   (clock_i),
    .in0_clk_o (in0_clk_i),
    .in1_clk_o (in1_clk_i)
  );
  gloe_output_gate #(
    .POR_CYCLES (20'h8)
  ) u_gloe_output_gate (
    .clock_i                 (clock_i),
    .sys_rst_i               (sys_rst_i),
    .in0_clk_i               (in0_clk_i),
    .in1_clk_i               (in1_clk_i),
    .src_sel_i               (src_sel_i),
    .out_en_i                (out_en_i),
    .clk_true_o              (clk_true_o),
    .clk_comp_o              (clk_comp_o),
    .runt_suppressor_ready_o (runt_suppressor_ready_o)
  );
  initial forever #20 clock_i = ~clock_i;
  task tk(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task t_reset;
    sys_rst_i = 1'h1;
    tk(20);
    sys_rst_i = 1'h0;
    tk(2);
    `CK("ready", 1'h0, runt_suppressor_ready_o)
    tk(8);
    `CK("ready", 1'h1, runt_suppressor_ready_o)
  endtask
  task t_enable;
    logic h;
    h = 1'h0;
    out_en_i = 1'h1;
    repeat (12) begin
      tk(1);
      h |= clk_true_o;
    end
    `CK("enabled", 1'h1, h)
  endtask
  task t_disable;
    logic h;
    h = 1'h0;
    out_en_i = 1'h0;
    tk(10);
    repeat (16) begin
      tk(1);
      h |= clk_true_o;
    end
    `CK("disabled", 1'h0, h)
  endtask
  task t_sel1;
    logic p;
    src_sel_i = 1'h1;
    out_en_i = 1'h1;
    tk(12);
    p = in1_clk_i;
    repeat (16) begin
      tk(1);
      `CK("follow", p, clk_true_o)
      `CK("comp", ~p, clk_comp_o)
      p = in1_clk_i;
    end
  endtask
  task test_done;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin t_reset; t_enable; t_disable; t_sel1; test_done; end
  initial begin tk(400); n_errors++; test_done; end
endmodule // test_glitchless_output_enable
